/* field_side_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// field side: isolated 24 V input and temperature sensor
module field_side_model (
    input  wire logic       aclk,
    input  wire logic       pulse_req,
    input  wire logic [7:0] temp_set,
    output var  logic       hw_trigger_in,
    output var  logic [7:0] temp_sample
);
    int hold = 0;

    // pulse lasts 8 cycles so the two-stage synchroniser cannot miss it
    always @(posedge aclk) begin
        if (pulse_req) hold <= 8;
        else if (hold > 0) hold <= hold - 1;
    end
    assign hw_trigger_in = (hold > 0);
    assign temp_sample   = temp_set;
endmodule

`default_nettype wire

/* quad_watchdog_timer_alarm.sv */
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Function
// - level one interrupt+warn, level two reset
// - watchdog 0 expiry sets warning relay
// - two software-selectable reset relay modes
// - mode one: assert on expiry, 2 s
// - mode two: assert armed, drop on expiry until cleared
// - four independent 8-bit channels
// - load value first, count when gated
// - timer 0 gated by software or input
// - timers 1 to 3 software gate only
// - watchdog decrements to 0, 0 expires
// - retrigger reloads running watchdog
// - alarm only through enabled outputs
// - enabled watchdog starts on first retrigger
// - watchdog 0 started by software or input
// - status shows channels and temperature
// - temperature over threshold may interrupt
// - input retriggers on selected edges
// - input gates timer 0 on edges
// - mode 2, time base 1 to 3
// - reload 1 to 255, base 1 to 3
// - delay 1 to 255, base 1 to 3
// - trigger, warning, relays only channel 0
// - hardware gate only on channel 0
module quad_watchdog_timer_alarm
    import wdt_pkg::*;
#(
    parameter int  NUM_CH    = 4,
    parameter int  CNT_W     = 8,
    parameter longint HOLD_CYC = RELAY_HOLD_CYC,
    parameter longint US_CYC   = TB_US_CYC,
    parameter longint MS_CYC   = TB_MS_CYC,
    parameter longint S_CYC    = TB_S_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        hw_trigger_in,
    input  wire logic [7:0]  temp_sample,
    output var  logic        warn_relay,
    output var  logic        reset_relay,
    output var  logic        irq
);

    // ==========================================================
    // input synchronisers
    logic       trig_s1_r, trig_s2_r, trig_s3_r;
    logic [7:0] temp_s1_r, temp_s2_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_s3_r <= 1'b0;
            temp_s1_r <= 8'h00;
            temp_s2_r <= 8'h00;
        end else begin
            trig_s1_r <= hw_trigger_in;
            trig_s2_r <= trig_s1_r;
            trig_s3_r <= trig_s2_r;   // history for edge detection only
            temp_s1_r <= temp_sample;  // slow sensor value, settles long before use
            temp_s2_r <= temp_s1_r;
        end
    end

    logic [31:0] alarm_cfg_r;
    logic        hw_edge;
    // edge selection shared by trigger and gate functions
    assign hw_edge = (alarm_cfg_r[ALM_EDGE_LSB]     &  trig_s2_r & ~trig_s3_r) |
                     (alarm_cfg_r[ALM_EDGE_LSB + 1] & ~trig_s2_r &  trig_s3_r);

    // ==========================================================
    // axi4-lite slave, one outstanding write and one read
    logic        aw_held_r, w_held_r;
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        wr_fire;
    logic [31:0] ch_ctrl_r [NUM_CH];
    logic [31:0] temp_thr_r;
    logic [NUM_CH-1:0] cmd_start, cmd_stop, cmd_trig;
    logic [31:0] wmerged;

    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_r && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_held_r && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_r > ADDR_TEMP_VAL || aw_addr_r[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // byte-lane merge helper
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) r[b*8 +: 8] = nw[b*8 +: 8];
        end
        return r;
    endfunction

    // command strobes last one cycle
    always_comb begin
        cmd_start = '0;
        cmd_stop  = '0;
        cmd_trig  = '0;
        if (wr_fire && aw_addr_r == ADDR_CMD) begin
            cmd_start = w_data_r[CMD_START_LSB +: NUM_CH];
            cmd_stop  = w_data_r[CMD_STOP_LSB  +: NUM_CH];
            cmd_trig  = w_data_r[CMD_TRIG_LSB  +: NUM_CH];
        end
    end

    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm_cfg_r <= 32'h0000_0000;
            temp_thr_r  <= 32'h0000_00FF;
        end else if (wr_fire) begin
            if (aw_addr_r == ADDR_ALARM)    alarm_cfg_r <= merge(alarm_cfg_r, w_data_r, w_strb_r) & 32'h0000_00FF;
            if (aw_addr_r == ADDR_TEMP_THR) temp_thr_r  <= merge(temp_thr_r, w_data_r, w_strb_r) & 32'h0000_00FF;
        end
    end

    // ==========================================================
    // channels
    logic [CNT_W-1:0]  cnt_r [NUM_CH];
    logic [31:0]       pre_r [NUM_CH];
    logic [NUM_CH-1:0] run_r, exp_r;
    logic              gate0_r;

    // hardware gate toggles timer 0 running state on each selected edge
    always_ff @(posedge aclk) begin
        if (!aresetn) gate0_r <= 1'b0;
        else if (hw_edge && alarm_cfg_r[ALM_HW_GATE_BIT]) gate0_r <= ~gate0_r;
    end

    generate
        for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
            logic [31:0] ctl;
            logic        is_wd, start, trig, stop, tick, cfg_wr;
            logic [31:0] tb_lim;
            assign ctl    = ch_ctrl_r[c];
            assign is_wd  = ctl[CTL_WDOG_BIT];
            assign cfg_wr = wr_fire && aw_addr_r == ADDR_CH_CTRL0 + 8'(4*c);
            // hardware sources reach channel 0 only
            if (c == 0) begin : g_hw
                assign trig  = cmd_trig[c] | (alarm_cfg_r[ALM_HW_TRIG_BIT] & is_wd & hw_edge);
                assign start = cmd_start[c] | (alarm_cfg_r[ALM_HW_GATE_BIT] & !is_wd & hw_edge & !gate0_r);
                assign stop  = cmd_stop[c]  | (alarm_cfg_r[ALM_HW_GATE_BIT] & !is_wd & hw_edge & gate0_r);
            end else begin : g_sw
                assign trig  = cmd_trig[c];
                assign start = cmd_start[c];
                assign stop  = cmd_stop[c];
            end
            // time-base select 1..3; other values fall back to microseconds
            always_comb begin
                case (ctl[CTL_BASE_LSB +: 2])
                    2'h2:    tb_lim = 32'(MS_CYC);
                    2'h3:    tb_lim = 32'(S_CYC);
                    default: tb_lim = 32'(US_CYC);
                endcase
            end
            assign tick = run_r[c] && (pre_r[c] >= tb_lim - 32'h1);

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    ch_ctrl_r[c] <= 32'h0000_0000;
                end else if (cfg_wr) begin
                    ch_ctrl_r[c] <= merge(ch_ctrl_r[c], w_data_r, w_strb_r) & 32'h0007_33FF;
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cnt_r[c] <= '0;
                    pre_r[c] <= 32'h0;
                    run_r[c] <= 1'b0;
                    exp_r[c] <= 1'b0;
                end else if (cfg_wr || stop) begin
                    cnt_r[c] <= cfg_wr ? w_data_r[CTL_RELOAD_LSB +: CNT_W] : ctl[CTL_RELOAD_LSB +: CNT_W];
                    pre_r[c] <= 32'h0;
                    run_r[c] <= 1'b0;
                    exp_r[c] <= 1'b0;
                end else if (ctl[CTL_ENA_BIT] && ((is_wd && trig) || (!is_wd && start))) begin
                    cnt_r[c] <= ctl[CTL_RELOAD_LSB +: CNT_W];
                    pre_r[c] <= 32'h0;
                    run_r[c] <= 1'b1;
                end else if (tick) begin
                    pre_r[c] <= 32'h0;
                    if (cnt_r[c] <= CNT_W'(1)) begin
                        if (!is_wd && ctl[CTL_MODE_LSB +: 2] == MODE_TIMER_PERIODIC) begin
                            cnt_r[c] <= ctl[CTL_RELOAD_LSB +: CNT_W];
                        end else begin
                            cnt_r[c] <= '0;
                            run_r[c] <= 1'b0;
                        end
                        exp_r[c] <= 1'b1;
                    end else begin
                        cnt_r[c] <= cnt_r[c] - CNT_W'(1);
                    end
                end else if (run_r[c]) begin
                    pre_r[c] <= pre_r[c] + 32'h1;
                end
            end
        end
    endgenerate

    // one-cycle expiry pulse of watchdog 0
    logic exp0_d_r;
    logic wd0_expire;
    always_ff @(posedge aclk) begin
        if (!aresetn) exp0_d_r <= 1'b0;
        else exp0_d_r <= exp_r[0];
    end
    assign wd0_expire = exp_r[0] && !exp0_d_r && ch_ctrl_r[0][CTL_WDOG_BIT];

    // ==========================================================
    // temperature and interrupt
    logic temp_warn_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) temp_warn_r <= 1'b0;
        else if (!alarm_cfg_r[ALM_TEMP_EN_BIT]) temp_warn_r <= 1'b0;
        else if (temp_s2_r > temp_thr_r[7:0]) temp_warn_r <= 1'b1;
    end

    logic [NUM_CH-1:0] irq_en;
    for (genvar c = 0; c < NUM_CH; c++) begin : g_irq
        assign irq_en[c] = ch_ctrl_r[c][CTL_IRQ_BIT];
    end

    // level one alarm: interrupt from enabled flags only
    logic irq_src;
    assign irq_src = |(exp_r & irq_en) | temp_warn_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) irq <= 1'b0;
        else irq <= irq_src;
    end

    // ==========================================================
    // relays
    relay_state_type rly_r;
    logic [31:0]     hold_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) warn_relay <= 1'b0;
        else if (!alarm_cfg_r[ALM_WARN_EN_BIT] || !exp_r[0]) warn_relay <= 1'b0;
        else if (ch_ctrl_r[0][CTL_WDOG_BIT]) warn_relay <= 1'b1;
    end

    // reset relay: hold timer; after the hold the state waits in RLY_DONE until exp_r[0] clears
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rly_r  <= RLY_IDLE;
            hold_r <= 32'h0;
        end else if (!alarm_cfg_r[ALM_RST_EN_BIT]) begin
            rly_r  <= RLY_IDLE;
            hold_r <= 32'h0;
        end else begin
            case (rly_r)
                RLY_IDLE: begin
                    hold_r <= 32'h0;
                    if (wd0_expire) rly_r <= RLY_HOLD;
                end
                RLY_HOLD: begin
                    hold_r <= hold_r + 32'h1;
                    if (hold_r >= 32'(HOLD_CYC) - 32'h1) rly_r <= RLY_DONE;
                end
                RLY_DONE: begin
                    if (!exp_r[0]) rly_r <= RLY_IDLE;
                end
                default: rly_r <= RLY_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) reset_relay <= 1'b0;
        else if (!alarm_cfg_r[ALM_RST_EN_BIT]) reset_relay <= 1'b0;
        else if (alarm_cfg_r[ALM_RST_MODE_BIT])
            reset_relay <= ch_ctrl_r[0][CTL_ENA_BIT] && rly_r == RLY_IDLE && !wd0_expire;
        else
            reset_relay <= rly_r == RLY_HOLD || wd0_expire;
    end

    // ==========================================================
    // read channel
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0;
        for (int c = 0; c < NUM_CH; c++) begin
            if (s_axi_araddr == ADDR_CH_CTRL0 + 8'(4*c))  rd_val = ch_ctrl_r[c];
            if (s_axi_araddr == ADDR_CH_VALUE0 + 8'(4*c)) rd_val = 32'(cnt_r[c]);
        end
        case (s_axi_araddr)
            ADDR_ALARM:    rd_val = alarm_cfg_r;
            ADDR_STATUS:   rd_val = 32'(run_r) | (32'(exp_r) << ST_EXP_LSB)
                                  | (32'(temp_warn_r) << ST_TEMP_BIT) | (32'(gate0_r) << ST_GATE_BIT);
            ADDR_TEMP_THR: rd_val = temp_thr_r;
            ADDR_TEMP_VAL: rd_val = 32'(temp_s2_r);
            default:       ;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= (s_axi_araddr > ADDR_TEMP_VAL || s_axi_araddr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // checks
    // plain decrement of channel 0: no command stop, reload or restart competes
    function automatic logic tick_any_guard();
        return g_ch[0].tick && cnt_r[0] > CNT_W'(1) && !cmd_stop[0] && !g_ch[0].cfg_wr
               && !(g_ch[0].start && !ch_ctrl_r[0][CTL_WDOG_BIT]) && !(g_ch[0].trig && ch_ctrl_r[0][CTL_WDOG_BIT]);
    endfunction

    chk_warn_follows_exp: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(exp_r[0]) && alarm_cfg_r[ALM_WARN_EN_BIT] && ch_ctrl_r[0][CTL_WDOG_BIT]
        && $stable(alarm_cfg_r) |=> warn_relay) else $error("warning relay missed");
    chk_warn_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
        !$past(alarm_cfg_r[ALM_WARN_EN_BIT]) |-> !warn_relay) else $error("warning relay while off");
    chk_rst_pulse_start: assert property (@(posedge aclk) disable iff (!aresetn)
        wd0_expire && alarm_cfg_r[ALM_RST_EN_BIT] && !alarm_cfg_r[ALM_RST_MODE_BIT] |=> reset_relay)
        else $error("reset relay missed");
    chk_rst_off_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
        !$past(alarm_cfg_r[ALM_RST_EN_BIT]) |-> !reset_relay) else $error("reset relay while off");
    chk_count_down: assert property (@(posedge aclk) disable iff (!aresetn)
        tick_any_guard() |=> cnt_r[0] == $past(cnt_r[0]) - CNT_W'(1)) else $error("count not decremented");
    chk_retrig_reload: assert property (@(posedge aclk) disable iff (!aresetn)
        cmd_trig[0] && ch_ctrl_r[0][CTL_ENA_BIT] && ch_ctrl_r[0][CTL_WDOG_BIT] && !cmd_stop[0]
        && !g_ch[0].cfg_wr |=> run_r[0] && cnt_r[0] == ch_ctrl_r[0][CTL_RELOAD_LSB +: CNT_W])
        else $error("retrigger did not reload");
    chk_exp_latched: assert property (@(posedge aclk) disable iff (!aresetn)
        exp_r[1] && !cmd_stop[1] && !g_ch[1].cfg_wr |=> exp_r[1]) else $error("expiry flag lost");
    chk_irq_source: assert property (@(posedge aclk) disable iff (!aresetn)
        irq |-> $past(irq_src)) else $error("spurious interrupt");
    chk_temp_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        alarm_cfg_r[ALM_TEMP_EN_BIT] && temp_s2_r > temp_thr_r[7:0] |=> temp_warn_r)
        else $error("temperature warning missed");

    cov_wd0_expire: cover property (@(posedge aclk) wd0_expire);
    cov_relay_done: cover property (@(posedge aclk) rly_r == RLY_DONE);
    cov_hw_edge:    cover property (@(posedge aclk) hw_edge && alarm_cfg_r[ALM_HW_TRIG_BIT]);
    cov_temp_warn:  cover property (@(posedge aclk) $rose(temp_warn_r));

endmodule

`default_nettype wire

/* quad_watchdog_timer_alarm_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fails++; \
    $display("unexpected %s exp %h got %h", nm, ex, got); end end

module quad_watchdog_timer_alarm_tb;
    import wdt_pkg::*;
    localparam longint HOLD = 20;  // 2 s relay hold shrunk to keep the run short
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, pulse_req = 0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, temp_set = 8'h00;
    logic [31:0] wdata = 32'h0, rd;
    logic [1:0]  rs, bs;
    wire logic awready, wready, bvalid, arready, rvalid, hw_trig, warn_relay, reset_relay, irq;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0]  temp_sample;
    int fails = 0, check_count = 0;

    quad_watchdog_timer_alarm #(.HOLD_CYC(HOLD), .US_CYC(2), .MS_CYC(4), .S_CYC(8)) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .hw_trigger_in(hw_trig),
        .temp_sample(temp_sample), .warn_relay(warn_relay), .reset_relay(reset_relay), .irq(irq));

    field_side_model field (.aclk(aclk), .pulse_req(pulse_req), .temp_set(temp_set),
        .hw_trigger_in(hw_trig), .temp_sample(temp_sample));

    initial begin
        forever #2.5 aclk = ~aclk;
    end

    // ==========================================================
    // bus tasks: each channel released at the edge it is taken
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bs = bresp;
        bready <= 1'b0;
        @(posedge aclk);  // spare edge so the next call never reassigns in this step
    endtask

    task automatic rdr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ==========================================================
    // test sequence
    initial begin
        int n;
        n = 0;
        cyc(5);
        aresetn <= 1'b1;
        cyc(1);
        rdr(ADDR_STATUS); `CHK("status", 32'h0, rd)
        rdr(8'h34); `CHK("bad resp", RESP_SLVERR, rs)
        wr(8'h34, 32'h0000_0001); `CHK("bad wr resp", RESP_SLVERR, bs)
        $display("test reset done");
        // watchdog 0 armed but idle until the first retrigger
        wr(ADDR_ALARM, 32'h0000_0003);
        wr(ADDR_CH_CTRL0, 32'h0007_0103);
        cyc(20);
        rdr(ADDR_CH_VALUE0); `CHK("idle count", 32'h0000_0003, rd)
        `CHK("warn early", 1'b0, warn_relay)
        wr(ADDR_CMD, 32'h0000_0100);
        while (!warn_relay && n < 50) begin
            cyc(1);
            n++;
        end
        `CHK("expiry late", 1'b1, n < 12)
        cyc(2);
        `CHK("warn", 1'b1, warn_relay)
        `CHK("reset relay", 1'b1, reset_relay)
        `CHK("irq", 1'b1, irq)
        cyc(HOLD + 5);
        `CHK("reset end", 1'b0, reset_relay)
        rdr(ADDR_STATUS); `CHK("ch0 expired", 1'b1, rd[ST_EXP_LSB])
        $display("test watchdog0 done");
        // channel 1 kept alive by retriggers, then left to run down
        wr(ADDR_CH_CTRL0 + 8'h04, 32'h0005_0205);
        repeat (8) wr(ADDR_CMD, 32'h0000_0200);
        rdr(ADDR_STATUS); `CHK("kept alive", 1'b0, rd[ST_EXP_LSB + 1])
        cyc(40);
        rdr(ADDR_STATUS); `CHK("ch1 expired", 1'b1, rd[ST_EXP_LSB + 1])
        $display("test retrigger done");
        // timer 2 loaded first, counts only after its software gate
        wr(ADDR_CH_CTRL0 + 8'h08, 32'h0004_21FF);
        rdr(ADDR_STATUS); `CHK("t2 idle", 1'b0, rd[ST_RUN_LSB + 2])
        wr(ADDR_CMD, 32'h0000_0004);
        rdr(ADDR_STATUS); `CHK("t2 run", 1'b1, rd[ST_RUN_LSB + 2])
        // timer 0 gated by the isolated input on rising edges only
        wr(ADDR_ALARM, 32'h0000_0030);
        wr(ADDR_CH_CTRL0, 32'h0004_23FF);
        pulse_req <= 1'b1;
        cyc(1);
        pulse_req <= 1'b0;
        cyc(15);
        rdr(ADDR_STATUS); `CHK("hw gate", 1'b1, rd[ST_RUN_LSB])
        $display("test timers done");
        temp_set <= 8'h50;
        wr(ADDR_TEMP_THR, 32'h0000_0040);
        wr(ADDR_ALARM, 32'h0000_0080);
        cyc(5);
        rdr(ADDR_STATUS); `CHK("temp warn", 1'b1, rd[ST_TEMP_BIT])
        $display("test temperature done");
        // watchdog 0 started by the input, reset relay in mode two
        wr(ADDR_CH_CTRL0, 32'h0005_0103);
        wr(ADDR_ALARM, 32'h0000_002E);
        cyc(2);
        `CHK("rst armed", 1'b1, reset_relay)
        pulse_req <= 1'b1;
        cyc(1);
        pulse_req <= 1'b0;
        cyc(14);
        `CHK("rst dropped", 1'b0, reset_relay)
        `CHK("warn off", 1'b0, warn_relay)
        rdr(ADDR_STATUS); `CHK("hw start", 1'b1, rd[ST_EXP_LSB])
        cyc(HOLD);
        `CHK("rst still low", 1'b0, reset_relay)
        wr(ADDR_CH_CTRL0, 32'h0005_0103);
        cyc(2);
        `CHK("rst back", 1'b1, reset_relay)
        $display("test reset mode two done");
        report_and_stop();
    end

    // hang guard, well beyond the expected run
    initial begin
        #20000;
        fails++;
        report_and_stop();
    end
endmodule

`default_nettype wire

/* wdt_pkg.sv */
package wdt_pkg;

    // ==========================================================
    // register map (byte addresses, one aligned word each)
    localparam logic [7:0] ADDR_CH_CTRL0  = 8'h00;  // channel control, +4 per channel
    localparam logic [7:0] ADDR_CH_VALUE0 = 8'h10;  // live count, +4 per channel
    localparam logic [7:0] ADDR_CMD       = 8'h20;  // command strobes, write only
    localparam logic [7:0] ADDR_ALARM     = 8'h24;  // relay / trigger configuration
    localparam logic [7:0] ADDR_STATUS    = 8'h28;  // status readback
    localparam logic [7:0] ADDR_TEMP_THR  = 8'h2C;  // temperature threshold
    localparam logic [7:0] ADDR_TEMP_VAL  = 8'h30;  // sampled temperature, read only

    // ==========================================================
    // channel control fields
    localparam int CTL_RELOAD_LSB = 0;   // 8-bit reload / delay value
    localparam int CTL_BASE_LSB   = 8;   // 2-bit time-base select
    localparam int CTL_MODE_LSB   = 12;  // 2-bit mode
    localparam int CTL_WDOG_BIT   = 16;  // 1 = watchdog, 0 = timer
    localparam int CTL_IRQ_BIT    = 17;  // interrupt enable
    localparam int CTL_ENA_BIT    = 18;  // channel enabled / armed

    localparam logic [1:0] MODE_TIMER_PERIODIC = 2'h2;

    // ==========================================================
    // command word: bits [3:0] start/gate-on, [7:4] stop, [11:8] retrigger
    localparam int CMD_START_LSB = 0;
    localparam int CMD_STOP_LSB  = 4;
    localparam int CMD_TRIG_LSB  = 8;

    // ==========================================================
    // alarm configuration fields
    localparam int ALM_WARN_EN_BIT  = 0;
    localparam int ALM_RST_EN_BIT   = 1;
    localparam int ALM_RST_MODE_BIT = 2;  // 0: pulse on expiry, 1: drop on expiry
    localparam int ALM_HW_TRIG_BIT  = 3;  // hw input retriggers watchdog 0
    localparam int ALM_HW_GATE_BIT  = 4;  // hw input gates timer 0
    localparam int ALM_EDGE_LSB     = 5;  // [5] rising, [6] falling
    localparam int ALM_TEMP_EN_BIT  = 7;

    // status fields: [3:0] running, [7:4] expired, [8] temp warn, [9] gate level
    localparam int ST_RUN_LSB   = 0;
    localparam int ST_EXP_LSB   = 4;
    localparam int ST_TEMP_BIT  = 8;
    localparam int ST_GATE_BIT  = 9;

    // ==========================================================
    // timing
    localparam longint CLK_HZ       = 200_000_000;
    localparam longint RELAY_HOLD_MS = 2000;
    localparam longint RELAY_HOLD_CYC = CLK_HZ / 1000 * RELAY_HOLD_MS;
    localparam longint TB_US_CYC     = CLK_HZ / 1_000_000;  // unit 1: microseconds
    localparam longint TB_MS_CYC     = CLK_HZ / 1000;       // unit 2: milliseconds
    localparam longint TB_S_CYC      = CLK_HZ;              // unit 3: seconds

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        RLY_IDLE = 2'b00,
        RLY_HOLD = 2'b01,
        RLY_DONE = 2'b11
    } relay_state_type;

endpackage
